// [cfg_far_side_model.sv]
// Far-side model: configuring host and serial flash
`timescale 1ns/1ps
`default_nettype none
module cfg_far_side_model (
   input wire logic i_sclk,
   input wire logic i_sclk_oe,
   input wire logic i_ss_n,
   input wire logic i_line0,
   output logic o_link_clk,
   output logic o_line0,
   output logic o_line1,
   output logic [7:0] o_cmd
);
   int cmd_cnt;

   initial begin
      o_link_clk = 1'b1;
      o_line0 = 1'b0;
      o_line1 = 1'b0;
      o_cmd = 8'h00;
      cmd_cnt = 0;
   end

   // ---------------------------------------------
   // Host side, passive load
   // ---------------------------------------------
   // clock runs only inside a frame
   task automatic send_frame(input logic [7:0] b, input int pre);
      for (int i = 0; i < pre + 8; i++) begin
         o_link_clk = 1'b0;
         o_line0 = (i < pre) ? 1'b1 : b[7 - (i - pre)];
         #32;
         o_link_clk = 1'b1;
         #32;
      end
      // Released line shows inverse, never a stale value
      o_line0 = ~o_line0;
   endtask : send_frame

   // ---------------------------------------------
   // Flash side, active load
   // ---------------------------------------------
   // flash listens only while selected
   always @(posedge i_sclk or posedge i_ss_n) begin
      if (i_ss_n) begin
         cmd_cnt <= 0;
         o_line1 <= ~o_line1;
      end else if (i_sclk_oe) begin
         if (cmd_cnt < 8) begin
            o_cmd <= {o_cmd[6:0], i_line0};
            cmd_cnt <= cmd_cnt + 1;
         end else begin
            o_line1 <= 1'b1;
         end
      end
   end
endmodule : cfg_far_side_model
`default_nettype wire

// [cfg_pin_pkg.sv]
// Shared types and constants for the configuration pin and mode control
package cfg_pin_pkg;

   // -------------------------------------------------------------
   // Sequencer states
   // -------------------------------------------------------------
   typedef enum logic [2:0] {ST_HOLD, ST_LOAD, ST_ERROR, ST_WAIT_DONE, ST_USER} state_type;

   // -------------------------------------------------------------
   // Pin sampling
   // -------------------------------------------------------------
   typedef struct packed {
      logic reconfig_n;
      logic ss_n;
      logic cs;
      logic [2:0] width_sel;
      logic [1:0] image_sel;
      logic test_n;
      logic done;
      logic d0;
      logic d1;
   } pin_sync_type;

   localparam logic SS_PASSIVE = 1'b0;
   localparam int DATA_LINES = 32;

   // -------------------------------------------------------------
   // Bus width straps and codes
   // -------------------------------------------------------------
   localparam logic [2:0] WSEL_X1 = 3'h7;
   localparam logic [2:0] WSEL_X2 = 3'h6;
   localparam logic [2:0] WSEL_X4 = 3'h5;
   localparam logic [2:0] WSEL_X8 = 3'h4;
   localparam logic [2:0] WSEL_X16 = 3'h3;
   localparam logic [2:0] WSEL_X32 = 3'h2;
   localparam logic [2:0] WIDTH_X1 = 3'h0;
   localparam logic [2:0] WIDTH_X2 = 3'h1;
   localparam logic [2:0] WIDTH_X4 = 3'h2;
   localparam logic [2:0] WIDTH_X8 = 3'h3;
   localparam logic [2:0] WIDTH_X16 = 3'h4;
   localparam logic [2:0] WIDTH_X32 = 3'h5;

   // -------------------------------------------------------------
   // Serial framing
   // -------------------------------------------------------------
   localparam logic [7:0] FLASH_READ_CMD = 8'h03;
   localparam logic [3:0] CMD_BITS = 4'h8;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [3:0] ONE4 = 4'h1;
   localparam logic [2:0] ONE3 = 3'h1;

endpackage : cfg_pin_pkg

// [config_pin_mode_control.sv]
// Configuration mode select and configuration pin control
`timescale 1ns/1ps
`default_nettype none

module config_pin_mode_control (
   input wire logic I_CLK,
   input wire logic I_RESET_N,
   input wire logic I_LINK_CLK,
   input wire logic I_RECONFIG_N,
   input wire logic I_SLAVE_SELECT_N,
   input wire logic I_CHIP_SELECT_IN,
   input wire logic [2:0] I_CONFIG_WIDTH_SELECT,
   input wire logic [1:0] I_IMAGE_SELECT,
   input wire logic I_MULTI_IMAGE_EN,
   input wire logic I_TEST_N,
   input wire logic I_CONFIG_DONE_FLAG,
   input wire logic [31:0] I_CONFIG_DATA_LINE,
   input wire logic I_ID_MISMATCH,
   input wire logic I_CRC_FAIL,
   input wire logic I_REMOTE_UPDATE_FAIL,
   input wire logic I_LOAD_COMPLETE,
   output logic O_SLAVE_SELECT_N,
   output logic O_SLAVE_SELECT_N_OE,
   output logic O_CONFIG_SERIAL_CLOCK,
   output logic O_CONFIG_SERIAL_CLOCK_OE,
   output logic [31:0] O_CONFIG_DATA_LINE,
   output logic [31:0] O_CONFIG_DATA_LINE_OE,
   output logic O_CONFIG_CHIP_SELECT_OUT,
   output logic O_CONFIG_ERROR_FLAG_N,
   output logic O_CONFIG_ERROR_FLAG_OE,
   output logic O_CONFIG_DONE_FLAG,
   output logic O_CONFIG_DONE_FLAG_OE,
   output logic O_RESERVED_OUT,
   output logic O_PASSIVE_MODE,
   output logic O_USER_MODE,
   output logic [2:0] O_DATA_WIDTH,
   output logic [1:0] O_IMAGE_SELECT,
   output logic O_TEST_MODE,
   output logic [7:0] O_RX_BYTE,
   output logic O_RX_VALID
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   cfg_pin_pkg::pin_sync_type meta_reg;
   cfg_pin_pkg::pin_sync_type sy;
   cfg_pin_pkg::pin_sync_type pins;

   always_comb begin
      pins = '{I_RECONFIG_N, I_SLAVE_SELECT_N, I_CHIP_SELECT_IN, I_CONFIG_WIDTH_SELECT,
               I_IMAGE_SELECT, I_TEST_N, I_CONFIG_DONE_FLAG, I_CONFIG_DATA_LINE[0],
               I_CONFIG_DATA_LINE[1]};
   end

   // Straps are static during sampling, so a plain vector sync is enough
   always_ff @(posedge I_CLK) begin
      meta_reg <= pins;
      sy <= meta_reg;
   end

   function automatic logic [2:0] decode_width(input logic [2:0] sel);
      case (sel)
         cfg_pin_pkg::WSEL_X1: decode_width = cfg_pin_pkg::WIDTH_X1;
         cfg_pin_pkg::WSEL_X2: decode_width = cfg_pin_pkg::WIDTH_X2;
         cfg_pin_pkg::WSEL_X4: decode_width = cfg_pin_pkg::WIDTH_X4;
         cfg_pin_pkg::WSEL_X8: decode_width = cfg_pin_pkg::WIDTH_X8;
         cfg_pin_pkg::WSEL_X16: decode_width = cfg_pin_pkg::WIDTH_X16;
         cfg_pin_pkg::WSEL_X32: decode_width = cfg_pin_pkg::WIDTH_X32;
         default: decode_width = cfg_pin_pkg::WIDTH_X1;
      endcase
   endfunction : decode_width

   // ----------------------------------------------------------------
   // Link domain: passive serial receive
   // ----------------------------------------------------------------
   logic [1:0] lrst_reg, lcs_reg, lpas_reg;
   logic [7:0] lshift_reg, lshift_next, lbyte_reg, lbyte_next;
   logic [2:0] lcnt_reg, lcnt_next;
   logic ltog_reg, ltog_next;
   logic passive_reg;

   always_comb begin
      lshift_next = lshift_reg;
      lcnt_next = lcnt_reg;
      lbyte_next = lbyte_reg;
      ltog_next = ltog_reg;
      if (lcs_reg[1] && lpas_reg[1]) begin
         lshift_next = {lshift_reg[6:0], I_CONFIG_DATA_LINE[0]};
         lcnt_next = lcnt_reg + cfg_pin_pkg::ONE3;
         if (lcnt_reg == cfg_pin_pkg::BIT_LAST) begin
            lbyte_next = {lshift_reg[6:0], I_CONFIG_DATA_LINE[0]};
            ltog_next = ~ltog_reg;
         end
      end else begin
         lcnt_next = '0;
      end
   end

   // Link clock may stop between frames; toggle carries the byte event
   always_ff @(posedge I_LINK_CLK) begin
      lrst_reg <= {lrst_reg[0], I_RESET_N};
      lcs_reg <= {lcs_reg[0], sy.cs};
      lpas_reg <= {lpas_reg[0], passive_reg};
      if (!lrst_reg[1]) begin
         lshift_reg <= '0;
         lcnt_reg <= '0;
         lbyte_reg <= '0;
         ltog_reg <= 1'b0;
      end else begin
         lshift_reg <= lshift_next;
         lcnt_reg <= lcnt_next;
         lbyte_reg <= lbyte_next;
         ltog_reg <= ltog_next;
      end
   end

   // ----------------------------------------------------------------
   // Sequencer and pin drive
   // ----------------------------------------------------------------
   cfg_pin_pkg::state_type state_reg, state_next;
   logic [2:0] tog_reg, tog_next;
   logic reconfig_d_reg, passive_next;
   logic sclk_next, ss_next, ss_oe_next, sclk_oe_next, cs_out_next;
   logic err_next, err_oe_next, done_oe_next, resv_next, user_next, test_next;
   logic [31:0] dl_next, dl_oe_next;
   logic [2:0] width_next;
   logic [1:0] image_next;
   logic [7:0] cmd_reg, cmd_next, rx_shift_reg, rx_shift_next, rx_byte_next;
   logic [3:0] cmd_cnt_reg, cmd_cnt_next;
   logic [2:0] rx_cnt_reg, rx_cnt_next;
   logic rx_valid_next, rise, fail, cfg_drive, active_run;

   always_comb begin
      rise = sy.reconfig_n && !reconfig_d_reg;
      fail = I_ID_MISMATCH || I_CRC_FAIL || I_REMOTE_UPDATE_FAIL;
      state_next = state_reg;
      passive_next = passive_reg;
      width_next = O_DATA_WIDTH;
      image_next = O_IMAGE_SELECT;
      err_next = O_CONFIG_ERROR_FLAG_N;
      case (state_reg)
         cfg_pin_pkg::ST_HOLD: begin
            if (rise) begin
               state_next = cfg_pin_pkg::ST_LOAD;
               passive_next = (sy.ss_n == cfg_pin_pkg::SS_PASSIVE);
               width_next = decode_width(sy.width_sel);
               image_next = I_MULTI_IMAGE_EN ? sy.image_sel : '0;
            end
         end
         cfg_pin_pkg::ST_LOAD: begin
            if (fail) begin
               state_next = cfg_pin_pkg::ST_ERROR;
               err_next = 1'b0;
            end else if (I_LOAD_COMPLETE) begin
               state_next = cfg_pin_pkg::ST_WAIT_DONE;
            end
         end
         cfg_pin_pkg::ST_WAIT_DONE: begin
            if (sy.done) begin
               state_next = cfg_pin_pkg::ST_USER;
            end
         end
         cfg_pin_pkg::ST_ERROR: state_next = cfg_pin_pkg::ST_ERROR;
         cfg_pin_pkg::ST_USER: state_next = cfg_pin_pkg::ST_USER;
         default: state_next = cfg_pin_pkg::ST_HOLD;
      endcase
      if (!sy.reconfig_n) begin
         state_next = cfg_pin_pkg::ST_HOLD;
         err_next = 1'b1;
      end
      cfg_drive = (state_next == cfg_pin_pkg::ST_LOAD) || (state_next == cfg_pin_pkg::ST_WAIT_DONE)
                  || (state_next == cfg_pin_pkg::ST_ERROR);
      active_run = (state_reg == cfg_pin_pkg::ST_LOAD) && !passive_reg && sy.cs
                   && (state_next == cfg_pin_pkg::ST_LOAD);
      ss_oe_next = cfg_drive && !passive_next;
      ss_next = !active_run;
      sclk_oe_next = cfg_drive && !passive_next;
      sclk_next = active_run ? !O_CONFIG_SERIAL_CLOCK : 1'b1;
      dl_oe_next = '0;
      dl_oe_next[0] = cfg_drive && !passive_next;
      dl_oe_next[1] = cfg_drive && passive_next;
      dl_next = O_CONFIG_DATA_LINE;
      dl_next[1] = sy.d0;
      cs_out_next = (state_next == cfg_pin_pkg::ST_WAIT_DONE) || (state_next == cfg_pin_pkg::ST_USER);
      err_oe_next = cfg_drive;
      done_oe_next = !cs_out_next;
      resv_next = (state_next != cfg_pin_pkg::ST_USER);
      user_next = (state_next == cfg_pin_pkg::ST_USER);
      test_next = !sy.test_n;
      cmd_next = cmd_reg;
      cmd_cnt_next = cmd_cnt_reg;
      rx_shift_next = rx_shift_reg;
      rx_cnt_next = rx_cnt_reg;
      rx_byte_next = O_RX_BYTE;
      rx_valid_next = 1'b0;
      tog_next = {tog_reg[1:0], ltog_reg};
      if (state_reg == cfg_pin_pkg::ST_HOLD) begin
         cmd_next = cfg_pin_pkg::FLASH_READ_CMD;
         cmd_cnt_next = '0;
         rx_cnt_next = '0;
      end else if (active_run && O_CONFIG_SERIAL_CLOCK) begin
         // Falling edge launches command bits
         if (cmd_cnt_reg != cfg_pin_pkg::CMD_BITS) begin
            dl_next[0] = cmd_reg[7];
            cmd_next = {cmd_reg[6:0], 1'b0};
            cmd_cnt_next = cmd_cnt_reg + cfg_pin_pkg::ONE4;
         end else begin
            dl_next[0] = 1'b0;
         end
      end else if (active_run && cmd_cnt_reg == cfg_pin_pkg::CMD_BITS) begin
         rx_shift_next = {rx_shift_reg[6:0], sy.d1};
         rx_cnt_next = rx_cnt_reg + cfg_pin_pkg::ONE3;
         if (rx_cnt_reg == cfg_pin_pkg::BIT_LAST) begin
            rx_byte_next = {rx_shift_reg[6:0], sy.d1};
            rx_valid_next = 1'b1;
         end
      end
      if ((tog_reg[2] != tog_reg[1]) && passive_reg && sy.cs && state_reg == cfg_pin_pkg::ST_LOAD) begin
         rx_byte_next = lbyte_reg;
         rx_valid_next = 1'b1;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RESET_N) begin
         state_reg <= cfg_pin_pkg::ST_HOLD;
         reconfig_d_reg <= 1'b1;
         passive_reg <= 1'b0;
         tog_reg <= '0;
         cmd_reg <= cfg_pin_pkg::FLASH_READ_CMD;
         cmd_cnt_reg <= '0;
         rx_shift_reg <= '0;
         rx_cnt_reg <= '0;
         O_SLAVE_SELECT_N <= 1'b1;
         O_SLAVE_SELECT_N_OE <= 1'b0;
         O_CONFIG_SERIAL_CLOCK <= 1'b1;
         O_CONFIG_SERIAL_CLOCK_OE <= 1'b0;
         O_CONFIG_DATA_LINE <= '0;
         O_CONFIG_DATA_LINE_OE <= '0;
         O_CONFIG_CHIP_SELECT_OUT <= 1'b0;
         O_CONFIG_ERROR_FLAG_N <= 1'b1;
         O_CONFIG_ERROR_FLAG_OE <= 1'b0;
         O_CONFIG_DONE_FLAG <= 1'b0;
         O_CONFIG_DONE_FLAG_OE <= 1'b1;
         O_RESERVED_OUT <= 1'b1;
         O_PASSIVE_MODE <= 1'b0;
         O_USER_MODE <= 1'b0;
         O_DATA_WIDTH <= cfg_pin_pkg::WIDTH_X1;
         O_IMAGE_SELECT <= '0;
         O_TEST_MODE <= 1'b0;
         O_RX_BYTE <= '0;
         O_RX_VALID <= 1'b0;
      end else begin
         state_reg <= state_next;
         reconfig_d_reg <= sy.reconfig_n;
         passive_reg <= passive_next;
         tog_reg <= tog_next;
         cmd_reg <= cmd_next;
         cmd_cnt_reg <= cmd_cnt_next;
         rx_shift_reg <= rx_shift_next;
         rx_cnt_reg <= rx_cnt_next;
         O_SLAVE_SELECT_N <= ss_next;
         O_SLAVE_SELECT_N_OE <= ss_oe_next;
         O_CONFIG_SERIAL_CLOCK <= sclk_next;
         O_CONFIG_SERIAL_CLOCK_OE <= sclk_oe_next;
         O_CONFIG_DATA_LINE <= dl_next;
         O_CONFIG_DATA_LINE_OE <= dl_oe_next;
         O_CONFIG_CHIP_SELECT_OUT <= cs_out_next;
         O_CONFIG_ERROR_FLAG_N <= err_next;
         O_CONFIG_ERROR_FLAG_OE <= err_oe_next;
         O_CONFIG_DONE_FLAG <= 1'b0;
         O_CONFIG_DONE_FLAG_OE <= done_oe_next;
         O_RESERVED_OUT <= resv_next;
         O_PASSIVE_MODE <= passive_next;
         O_USER_MODE <= user_next;
         O_DATA_WIDTH <= width_next;
         O_IMAGE_SELECT <= image_next;
         O_TEST_MODE <= test_next;
         O_RX_BYTE <= rx_byte_next;
         O_RX_VALID <= rx_valid_next;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RESET_N);

   AST_MODE_SAMPLE: assert property (rise && state_reg == cfg_pin_pkg::ST_HOLD && sy.reconfig_n
      |=> O_PASSIVE_MODE == !$past(sy.ss_n)) else $error("mode not taken from slave select");
   AST_SS_DIR: assert property (O_SLAVE_SELECT_N_OE |-> !O_PASSIVE_MODE && !O_USER_MODE)
      else $error("slave select driven outside active load");
   AST_CS_GATE: assert property (!sy.cs && state_reg == cfg_pin_pkg::ST_LOAD |=> !O_RX_VALID)
      else $error("data accepted while unselected");
   AST_CSO: assert property (O_CONFIG_CHIP_SELECT_OUT == (state_reg == cfg_pin_pkg::ST_WAIT_DONE
      || state_reg == cfg_pin_pkg::ST_USER)) else $error("chip select out wrong");
   AST_ERR_SET: assert property (state_reg == cfg_pin_pkg::ST_LOAD && fail && sy.reconfig_n
      |=> !O_CONFIG_ERROR_FLAG_N && O_CONFIG_ERROR_FLAG_OE) else $error("error not flagged");
   AST_SCLK_DIR: assert property (O_CONFIG_SERIAL_CLOCK_OE |-> !O_PASSIVE_MODE)
      else $error("clock driven in passive mode");
   AST_DATA_DIR: assert property (O_CONFIG_DATA_LINE_OE[1] |-> O_PASSIVE_MODE && !O_CONFIG_DATA_LINE_OE[0])
      else $error("data line direction wrong");
   AST_WIDTH: assert property (rise && state_reg == cfg_pin_pkg::ST_HOLD && sy.width_sel == cfg_pin_pkg::WSEL_X1
      |=> O_DATA_WIDTH == cfg_pin_pkg::WIDTH_X1) else $error("default width not single bit");
   AST_IMAGE: assert property (rise && state_reg == cfg_pin_pkg::ST_HOLD && I_MULTI_IMAGE_EN
      |=> O_IMAGE_SELECT == $past(sy.image_sel)) else $error("image select not taken");
   AST_TEST: assert property (sy.test_n |=> !O_TEST_MODE) else $error("test mode while disabled");
   AST_RELEASE: assert property (O_USER_MODE |-> O_CONFIG_DATA_LINE_OE == '0 && !O_SLAVE_SELECT_N_OE
      && !O_CONFIG_SERIAL_CLOCK_OE && !O_CONFIG_ERROR_FLAG_OE) else $error("pins held in user mode");
   AST_RESERVED: assert property (!O_USER_MODE |-> O_RESERVED_OUT) else $error("reserved pin low");
   AST_RESTART: assert property (!sy.reconfig_n |=> state_reg == cfg_pin_pkg::ST_HOLD ##1 1'b1)
      else $error("reconfiguration did not restart");
   AST_DONE: assert property (state_reg == cfg_pin_pkg::ST_WAIT_DONE && !sy.done && sy.reconfig_n |=> !O_USER_MODE
      && !O_CONFIG_DONE_FLAG_OE) else $error("user mode with done held low");
   AST_ERR_STICKY: assert property (!O_CONFIG_ERROR_FLAG_N && sy.reconfig_n |=> !O_CONFIG_ERROR_FLAG_N)
      else $error("error flag cleared early");

   COV_ACTIVE_BYTE: cover property (!O_PASSIVE_MODE && O_RX_VALID);
   COV_PASSIVE_BYTE: cover property (O_PASSIVE_MODE && O_RX_VALID);
   COV_USER: cover property (state_reg == cfg_pin_pkg::ST_WAIT_DONE ##1 O_USER_MODE);
   COV_ERROR: cover property ($fell(O_CONFIG_ERROR_FLAG_N));

endmodule : config_pin_mode_control

`default_nettype wire

// [config_pin_mode_control_tb_top.sv]
// Self-checking bench for the configuration pin and mode control
`timescale 1ns/1ps
`default_nettype none
module config_pin_mode_control_tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic reconfig_n = 1'b0;
   logic ss_strap = 1'b0;
   logic cs_in = 1'b0;
   logic [2:0] width_sel = 3'h7;
   logic [1:0] image_sel = 2'h0;
   logic multi_en = 1'b0;
   logic test_n = 1'b1;
   logic done_hold_n = 1'b1;
   logic id_bad = 1'b0;
   logic crc_bad = 1'b0;
   logic upd_bad = 1'b0;
   logic load_done = 1'b0;
   logic ss_o, ss_oe, sclk_o, sclk_oe, cs_out, err_n, err_oe, done_o, done_oe, rsv, passive, user, test_mode, rx_valid;
   logic [31:0] d_o, d_oe, data_in;
   logic [2:0] width;
   logic [1:0] img_o;
   logic [7:0] rx_byte, flash_cmd, got;
   logic link_clk, host_line0, flash_line1, link_pin, ss_pin, done_pin, seen, a;
   int fails = 0;
   int comparisons = 0;
   int cycles = 0;

   // ---------------------------------------------
   // Pin resolution and instances
   // ---------------------------------------------
   assign ss_pin = ss_oe ? ss_o : ss_strap;
   assign link_pin = sclk_oe ? sclk_o : link_clk;
   assign done_pin = done_oe ? done_o : done_hold_n;
   assign data_in = {30'h0, d_oe[1] ? d_o[1] : flash_line1, d_oe[0] ? d_o[0] : host_line0};

   config_pin_mode_control uut (.I_CLK(clk), .I_RESET_N(rst_n), .I_LINK_CLK(link_pin), .I_RECONFIG_N(reconfig_n),
      .I_SLAVE_SELECT_N(ss_pin), .I_CHIP_SELECT_IN(cs_in), .I_CONFIG_WIDTH_SELECT(width_sel),
      .I_IMAGE_SELECT(image_sel), .I_MULTI_IMAGE_EN(multi_en), .I_TEST_N(test_n), .I_CONFIG_DONE_FLAG(done_pin),
      .I_CONFIG_DATA_LINE(data_in), .I_ID_MISMATCH(id_bad), .I_CRC_FAIL(crc_bad), .I_REMOTE_UPDATE_FAIL(upd_bad),
      .I_LOAD_COMPLETE(load_done), .O_SLAVE_SELECT_N(ss_o), .O_SLAVE_SELECT_N_OE(ss_oe),
      .O_CONFIG_SERIAL_CLOCK(sclk_o), .O_CONFIG_SERIAL_CLOCK_OE(sclk_oe), .O_CONFIG_DATA_LINE(d_o),
      .O_CONFIG_DATA_LINE_OE(d_oe), .O_CONFIG_CHIP_SELECT_OUT(cs_out), .O_CONFIG_ERROR_FLAG_N(err_n),
      .O_CONFIG_ERROR_FLAG_OE(err_oe), .O_CONFIG_DONE_FLAG(done_o), .O_CONFIG_DONE_FLAG_OE(done_oe),
      .O_RESERVED_OUT(rsv), .O_PASSIVE_MODE(passive), .O_USER_MODE(user), .O_DATA_WIDTH(width),
      .O_IMAGE_SELECT(img_o), .O_TEST_MODE(test_mode), .O_RX_BYTE(rx_byte), .O_RX_VALID(rx_valid));

   cfg_far_side_model model (.i_sclk(link_pin), .i_sclk_oe(sclk_oe), .i_ss_n(ss_pin), .i_line0(data_in[0]),
      .o_link_clk(link_clk), .o_line0(host_line0), .o_line1(flash_line1), .o_cmd(flash_cmd));

   // ---------------------------------------------
   // Clock, timeout and tasks
   // ---------------------------------------------
   initial begin
      forever #25 clk = ~clk;
   end

   // Ceiling well above the few hundred cycles the tests need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 10000) begin
         fails++;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v, input string what);
      comparisons++;
      if (got_v !== exp_v) begin
         fails++;
         $display("ERROR %0t %s got %0h exp %0h", $time, what, got_v, exp_v);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc

   task automatic reconfig(input logic ss);
      reconfig_n = 1'b0;
      ss_strap = ss;
      cyc(4);
      reconfig_n = 1'b1;
      cyc(5);
   endtask : reconfig

   task automatic wait_valid(input int lim);
      seen = 1'b0;
      repeat (lim) begin
         @(posedge clk);
         #1;
         if (rx_valid === 1'b1 && !seen) begin
            seen = 1'b1;
            got = rx_byte;
         end
      end
      @(negedge clk);
   endtask : wait_valid

   task automatic tally_and_finish;
      $display("Comparisons %0d mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish

   // ---------------------------------------------
   // Test sequence
   // ---------------------------------------------
   initial begin
      fork
         model.send_frame(8'h00, 4);
      join_none
      cyc(4);
      rst_n = 1'b1;
      cyc(20);
      chk({ss_oe, sclk_oe, cs_out, err_n, err_oe, done_oe, rsv, user}, 8'h16, "reset pins");
      chk(done_o, 1'b0, "done pulls low");
      test_n = 1'b0;
      cyc(4);
      chk(test_mode, 1'b1, "test on");
      test_n = 1'b1;
      cyc(4);
      chk(test_mode, 1'b0, "test off");
      for (int i = 0; i < 7; i++) begin
         width_sel = (i < 6) ? 3'(7 - i) : 3'h0;
         image_sel = i[1:0];
         multi_en = i[0];
         reconfig(1'b0);
         chk(width, (i < 6) ? 3'(i) : 3'h0, "width code");
         chk(img_o, i[0] ? i[1:0] : 2'h0, "image select");
         chk({passive, ss_oe, sclk_oe, rsv, err_oe}, 5'h13, "passive pins");
         chk(d_oe, 32'h0000_0002, "passive data dir");
         chk(d_o[1], host_line0, "line 1 echo");
      end
      cs_in = 1'b1;
      cyc(3);
      fork
         model.send_frame(8'hA5, 2);
         wait_valid(40);
      join
      chk(seen, 1'b1, "passive byte seen");
      chk(got, 8'hA5, "passive byte");
      cs_in = 1'b0;
      cyc(3);
      fork
         model.send_frame(8'h3C, 2);
         wait_valid(40);
      join
      chk(seen, 1'b0, "unselected byte");
      for (int k = 0; k < 3; k++) begin
         reconfig(1'b0);
         {id_bad, crc_bad, upd_bad} = 3'h4 >> k;
         cyc(1);
         {id_bad, crc_bad, upd_bad} = 3'h0;
         cyc(1);
         chk({err_n, err_oe}, 2'h1, "error flag");
         cyc(10);
         chk(err_n, 1'b0, "error sticky");
      end
      reconfig(1'b0);
      chk(err_n, 1'b1, "error cleared");
      load_done = 1'b1;
      done_hold_n = 1'b0;
      cyc(1);
      load_done = 1'b0;
      cyc(1);
      chk({done_oe, cs_out, user}, 3'h2, "completion");
      cyc(10);
      chk(user, 1'b0, "done held low");
      done_hold_n = 1'b1;
      cyc(5);
      chk({user, rsv, ss_oe, sclk_oe, err_oe, done_oe}, 6'h20, "user mode pins");
      chk(d_oe, 32'h0, "user data lines");
      cs_in = 1'b1;
      reconfig(1'b1);
      chk({passive, ss_oe, ss_o, sclk_oe}, 4'h5, "active pins");
      chk(d_oe, 32'h0000_0001, "active data dir");
      a = sclk_o;
      cyc(1);
      chk(sclk_o, !a, "active clock toggles");
      wait_valid(60);
      chk(seen, 1'b1, "active byte seen");
      chk(flash_cmd, cfg_pin_pkg::FLASH_READ_CMD, "flash command");
      cs_in = 1'b0;
      cyc(4);
      chk({ss_o, sclk_o}, 2'h3, "active deselected");
      tally_and_finish();
   end
endmodule : config_pin_mode_control_tb_top
`default_nettype wire
